/* hdl/binary_bcd_add_subtract_unit.sv */
// Top of the add/subtract unit: AXI4-Lite registers, parallel and serial
// binary units, and a five-digit bit-serial BCD accumulator.
// Assumes a single 125 MHz clock and a well-behaved AXI4-Lite master.
`timescale 1ns/1ns
`default_nettype none
`include "addsub_cfg.svh"
module binary_bcd_add_subtract_unit (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address channel
	input  wire logic [31:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// Write data channel
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// Write response channel
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Read address channel
	input  wire logic [31:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// Read data channel
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	// ==========================================================
	// Declarations
	logic                        aw_held;
	logic [31:0]                 aw_addr_q;
	logic                        w_held;
	logic [31:0]                 w_data_q;
	logic [3:0]                  w_strb_q;
	logic                        do_write;
	logic                        wr_mapped;
	logic                        rd_mapped;
	logic [31:0]                 wmask;
	logic [31:0]                 wval;
	logic [31:0]                 rd_word;
	logic                        sel_ctrl;
	logic                        sel_a;
	logic                        sel_b;
	logic                        sel_ser;
	logic                        sel_six;
	logic                        sel_bcd;
	logic [2:0]                  ctrl;
	logic [`ALU_WIDTH-1:0]       operand_a;
	logic [`ALU_WIDTH-1:0]       operand_b;
	addsub_pkg::par_result_type  par_result;
	logic                        ser_step;
	logic                        ser_restart;
	logic                        ser_a;
	logic                        ser_b;
	logic                        six_step;
	logic                        six_clear;
	logic [`SIX_OPERANDS-1:0]    six_bits;
	logic [`BCD_LONG_BITS-1:0]   long_reg;
	logic [`BCD_SHORT_BITS-1:0]  short_reg;
	logic [4:0]                  pos;
	logic                        carry_store;
	addsub_pkg::bcd_mode_type    mode_req;
	addsub_pkg::bcd_mode_type    mode;
	logic                        bcd_step;
	logic                        bcd_clear;
	logic                        bcd_data;
	logic                        mode_sub;
	logic                        at_home;
	logic                        at_w8;
	logic                        acc_bit;
	logic                        d_eff;
	logic                        c_now;
	logic                        sum_bit;
	logic                        c_out;
	logic [3:0]                  digit;
	logic                        dig_over;
	logic                        need_corr;
	logic [3:0]                  corr_digit;
	logic                        next_carry;
	logic [3:0]                  next_short;
	logic [4:0]                  next_pos;
	serial_unit_if               ser_if ();

	// ==========================================================
	// Helpers
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0;
		for (int i = 0; i < 4; i++) begin
			m[8*i +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction
	function automatic logic mapped(input logic [31:0] addr, input logic wr);
		logic hit;
		hit = (addr[31:5] == 27'h0) && (addr[1:0] == 2'h0);
		if (wr) begin
			hit = hit && (addr != `OFS_PAR_RESULT) && (addr != `OFS_BCD_ACC);
		end
		return hit;
	endfunction

	// ==========================================================
	// AXI4-Lite write path
	// Address and data are held separately so either may arrive first
	assign awready = ~aw_held & ~bvalid;
	assign wready = ~w_held & ~bvalid;
	assign do_write = aw_held & w_held & ~bvalid;
	assign wr_mapped = mapped(aw_addr_q, 1'b1);
	assign wmask = lane_mask(w_strb_q);
	assign wval = w_data_q & wmask;
	assign sel_ctrl = do_write & wr_mapped & (aw_addr_q == `OFS_CTRL);
	assign sel_a = do_write & wr_mapped & (aw_addr_q == `OFS_OPERAND_A);
	assign sel_b = do_write & wr_mapped & (aw_addr_q == `OFS_OPERAND_B);
	assign sel_ser = do_write & wr_mapped & (aw_addr_q == `OFS_SERIAL);
	assign sel_six = do_write & wr_mapped & (aw_addr_q == `OFS_SIX);
	assign sel_bcd = do_write & wr_mapped & (aw_addr_q == `OFS_BCD_CMD);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr_q <= 32'h0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	assign arready = ~rvalid;
	assign rd_mapped = mapped(araddr, 1'b0);
	assign rd_word =
		(araddr == `OFS_CTRL)       ? {29'h0, ctrl} :
		(araddr == `OFS_OPERAND_A)  ? {24'h0, operand_a} :
		(araddr == `OFS_OPERAND_B)  ? {24'h0, operand_b} :
		(araddr == `OFS_PAR_RESULT) ? {19'h0, par_result} :
		(araddr == `OFS_SERIAL)     ? {30'h0, ser_if.carry_state, ser_if.sum_bit} :
		(araddr == `OFS_SIX)        ? {27'h0, ser_if.six_carries, ser_if.six_sum} :
		(araddr == `OFS_BCD_CMD)    ? {24'h0, carry_store, mode_req, mode, pos} :
		(araddr == `OFS_BCD_ACC)    ? {12'h0, short_reg, long_reg} :
		32'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_mapped ? rd_word : 32'h0;
			rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Control and operand registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `CTRL_RESET;
			operand_a <= 8'h00;
			operand_b <= 8'h00;
		end else begin
			if (sel_ctrl) begin
				ctrl <= (ctrl & ~wmask[2:0]) | wval[2:0];
			end
			if (sel_a) begin
				operand_a <= (operand_a & ~wmask[7:0]) | wval[7:0];
			end
			if (sel_b) begin
				operand_b <= (operand_b & ~wmask[7:0]) | wval[7:0];
			end
		end
	end

	// ==========================================================
	// Command pulses, one cycle each
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ser_step <= 1'b0;
			ser_restart <= 1'b0;
			ser_a <= 1'b0;
			ser_b <= 1'b0;
			six_step <= 1'b0;
			six_clear <= 1'b0;
			six_bits <= 6'h00;
			bcd_step <= 1'b0;
			bcd_clear <= 1'b0;
			bcd_data <= 1'b0;
		end else begin
			ser_step <= sel_ser & w_strb_q[0] & ~wval[`CMD_AUX];
			ser_restart <= sel_ser & wval[`CMD_AUX];
			six_step <= sel_six & w_strb_q[0] & ~wval[`CMD_AUX];
			six_clear <= sel_six & wval[`CMD_AUX];
			bcd_step <= sel_bcd & wval[`BCD_STEP] & ~wval[`CMD_AUX];
			bcd_clear <= sel_bcd & wval[`CMD_AUX];
			if (sel_ser && w_strb_q[0]) begin
				ser_a <= wval[0];
				ser_b <= wval[1];
			end
			if (sel_six && w_strb_q[0]) begin
				six_bits <= wval[5:0];
			end
			if (sel_bcd && w_strb_q[0]) begin
				bcd_data <= wval[`BCD_DATA];
			end
		end
	end

	// ==========================================================
	// Parallel and serial binary units
	parallel_addsub u_parallel (
		.a      (operand_a),
		.b      (operand_b),
		.sub    (ctrl[`CTRL_SUB]),
		.ones   (ctrl[`CTRL_ONES]),
		.result (par_result)
	);
	assign ser_if.step = ser_step;
	assign ser_if.restart = ser_restart;
	assign ser_if.a_bit = ser_a;
	assign ser_if.b_bit = ser_b;
	assign ser_if.sub = ctrl[`CTRL_SUB];
	assign ser_if.active_low = ctrl[`CTRL_LOW];
	assign ser_if.six_step = six_step;
	assign ser_if.six_clear = six_clear;
	assign ser_if.six_bits = six_bits;
	serial_addsub u_serial (
		.aclk    (aclk),
		.aresetn (aresetn),
		.port_if (ser_if)
	);

	// ==========================================================
	// Bit-serial BCD accumulator datapath
	assign mode_sub = (mode == addsub_pkg::bcd_subtract);
	assign at_home = (pos == `BCD_POS_HOME);
	assign at_w8 = (pos[1:0] == 2'h3);
	assign acc_bit = long_reg[0];
	assign d_eff = bcd_data ^ mode_sub;
	assign c_now = at_home ? mode_sub : (carry_store ^ mode_sub);
	assign sum_bit = acc_bit ^ d_eff ^ c_now;
	assign c_out = (acc_bit & d_eff) | (c_now & (acc_bit ^ d_eff));
	assign digit = {sum_bit, short_reg[3:1]};
	assign dig_over = digit[3] & (digit[2] | digit[1]);
	// low carry is a decimal borrow
	assign need_corr = mode_sub ? ~c_out : (c_out | dig_over);
	assign corr_digit = digit + (mode_sub ? `BCD_SUB_CORR : `BCD_ADD_CORR);
	assign next_carry = (at_w8 && !mode_sub) ? need_corr : c_out;
	assign next_short = (at_w8 && need_corr) ? corr_digit : digit;
	assign next_pos = (pos == `BCD_POS_LAST) ? `BCD_POS_HOME : pos + 5'h01;
	always_ff @(posedge aclk) begin
		if (!aresetn || bcd_clear) begin
			long_reg <= 16'h0000;
			short_reg <= 4'h0;
			pos <= `BCD_POS_HOME;
			carry_store <= 1'b0;
		end else if (bcd_step) begin
			long_reg <= {short_reg[0], long_reg[15:1]};
			short_reg <= next_short;
			pos <= next_pos;
			// Stored inverted in subtract so reset means carry present
			carry_store <= next_carry ^ mode_sub;
		end
	end
	// Mode requests wait in their own flop until the register is home
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_req <= addsub_pkg::bcd_add;
			mode <= addsub_pkg::bcd_add;
		end else begin
			if (sel_bcd && w_strb_q[0]) begin
				mode_req <= addsub_pkg::bcd_mode_type'(wval[`BCD_MODE]);
			end
			if (at_home && !bcd_step) begin
				mode <= mode_req;
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/addsub_cfg.svh */
// Offsets, field positions, reset values and sizes of the add/subtract unit.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef ADDSUB_CFG_SVH
`define ADDSUB_CFG_SVH
// ==========================================================
// Datapath sizes
`define ALU_WIDTH       8
`define BCD_LONG_BITS   16
`define BCD_SHORT_BITS  4
`define BCD_POS_LAST    5'h13
`define BCD_POS_HOME    5'h00
`define BCD_ADD_CORR    4'h6
`define BCD_SUB_CORR    4'ha
`define SIX_OPERANDS    6
`define SIX_CARRY_BITS  4
// ==========================================================
// Register byte offsets
`define OFS_CTRL        32'h0000_0000
`define OFS_OPERAND_A   32'h0000_0004
`define OFS_OPERAND_B   32'h0000_0008
`define OFS_PAR_RESULT  32'h0000_000c
`define OFS_SERIAL      32'h0000_0010
`define OFS_SIX         32'h0000_0014
`define OFS_BCD_CMD     32'h0000_0018
`define OFS_BCD_ACC     32'h0000_001c
// ==========================================================
// Field positions and reset values
`define CTRL_SUB        0
`define CTRL_ONES       1
`define CTRL_LOW        2
`define CMD_AUX         8
`define BCD_DATA        0
`define BCD_MODE        1
`define BCD_STEP        2
`define CTRL_RESET      3'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

/* hdl/addsub_pkg.sv */
// Types shared by the add/subtract unit and its submodules.
// Assumes the configuration header is on the include path.
`default_nettype none
`include "addsub_cfg.svh"
package addsub_pkg;
	// ==========================================================
	// Types
	typedef enum logic [0:0] {
		bcd_subtract = 1'b0,
		bcd_add      = 1'b1
	} bcd_mode_type;
	typedef struct packed {
		logic                  borrow;
		logic                  ov_alt;
		logic                  ov_regen;
		logic                  overflow;
		logic                  carry_out;
		logic [`ALU_WIDTH-1:0] sum;
	} par_result_type;
endpackage
`default_nettype wire

/* hdl/serial_unit_if.sv */
// Bundle between the register front end and the serial adder unit.
// Assumes all signals are synchronous to the one system clock.
`timescale 1ns/1ns
`default_nettype none
`include "addsub_cfg.svh"
interface serial_unit_if;
	logic                       step;
	logic                       restart;
	logic                       a_bit;
	logic                       b_bit;
	logic                       sub;
	logic                       active_low;
	logic                       six_step;
	logic                       six_clear;
	logic [`SIX_OPERANDS-1:0]   six_bits;
	logic                       sum_bit;
	logic                       carry_state;
	logic                       six_sum;
	logic [`SIX_CARRY_BITS-1:0] six_carries;
	modport ctrl (output step, restart, a_bit, b_bit, sub, active_low, six_step, six_clear, six_bits,
		input sum_bit, carry_state, six_sum, six_carries);
	modport unit (input step, restart, a_bit, b_bit, sub, active_low, six_step, six_clear, six_bits,
		output sum_bit, carry_state, six_sum, six_carries);
endinterface
`default_nettype wire

/* hdl/parallel_addsub.sv */
// Parallel two's and one's complement adder/subtractor with overflow.
// Assumes operands are held stable by the register front end.
`timescale 1ns/1ns
`default_nettype none
`include "addsub_cfg.svh"
module parallel_addsub (
	// Operands
	input  wire logic [`ALU_WIDTH-1:0] a,
	input  wire logic [`ALU_WIDTH-1:0] b,
	// Mode
	input  wire logic                  sub,
	input  wire logic                  ones,
	// Result
	output addsub_pkg::par_result_type result
);
	localparam int W = `ALU_WIDTH;
	logic [W-1:0] x;
	logic         cin_first;
	logic         cin_final;
	logic [W+1:0] pass1;
	logic [W+1:0] pass2;
	logic [W:0]   ext;
	logic         c_alt;
	logic         add;
	// Returns carry out, carry into the sign, and the sum
	function automatic logic [W+1:0] sign_add(input logic [W-1:0] av, input logic [W-1:0] xv, input logic ci);
		logic [W-1:0] low;
		logic         cs;
		logic         ss;
		logic         co;
		low = {1'b0, av[W-2:0]} + {1'b0, xv[W-2:0]} + {{(W-1){1'b0}}, ci};
		cs = low[W-1];
		ss = av[W-1] ^ xv[W-1] ^ cs;
		co = (av[W-1] & xv[W-1]) | (cs & (av[W-1] ^ xv[W-1]));
		return {co, cs, ss, low[W-2:0]};
	endfunction
	assign x = b ^ {W{sub}};
	assign cin_first = sub & ~ones;
	assign pass1 = sign_add(a, x, cin_first);
	assign cin_final = ones ? pass1[W+1] : cin_first;
	assign pass2 = sign_add(a, x, cin_final);
	assign result.sum = pass2[W-1:0];
	assign result.carry_out = pass2[W+1];
	assign result.overflow = pass2[W] ^ pass2[W+1];
	assign result.ov_regen = pass2[W-1] ^ a[W-1] ^ x[W-1] ^ pass2[W+1];
	assign add = ~sub;
	assign ext = {1'b0, add, a[W-2:0]} + {1'b0, sub, x[W-2:0]} + {{W{1'b0}}, cin_final};
	assign c_alt = ext[W];
	assign result.ov_alt = (a[W-1] & ~c_alt & (~b[W-1] ^ add)) | (~a[W-1] & c_alt & (b[W-1] ^ add));
	assign result.borrow = ~pass2[W+1];
endmodule
`default_nettype wire

/* hdl/serial_addsub.sv */
// Bit-serial binary adder/subtractor and six-operand serial adder.
// Assumes one step pulse per operand bit, least significant bit first.
`timescale 1ns/1ns
`default_nettype none
`include "addsub_cfg.svh"
module serial_addsub (
	// Clock and reset
	input wire logic    aclk,
	input wire logic    aresetn,
	// Control and results
	serial_unit_if.unit port_if
);
	logic                       a_l;
	logic                       x_l;
	logic                       b_l;
	logic                       c_l;
	logic                       s_e;
	logic                       c_next;
	logic                       carry_ff;
	logic                       sum_q;
	logic [`SIX_CARRY_BITS-1:0] six_carry;
	logic                       six_q;
	logic [3:0]                 col;
	function automatic logic [3:0] ones_count(input logic [`SIX_OPERANDS-1:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < `SIX_OPERANDS; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction
	// XOR on data path: a minus b is the inverse of (not a) plus b
	assign a_l = port_if.a_bit ^ port_if.active_low;
	assign b_l = port_if.b_bit ^ port_if.active_low;
	assign x_l = a_l ^ port_if.sub;
	// Stored carry is inverted for active-high operands
	assign c_l = carry_ff ^ ~port_if.active_low;
	assign s_e = x_l ^ b_l ^ c_l ^ port_if.sub ^ port_if.active_low;
	assign c_next = (x_l & b_l) | (c_l & (x_l ^ b_l));
	assign col = ones_count(port_if.six_bits) + six_carry;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			carry_ff <= 1'b1;
			sum_q <= 1'b0;
		end else if (port_if.restart) begin
			carry_ff <= ~port_if.active_low;
		end else if (port_if.step) begin
			sum_q <= s_e;
			carry_ff <= c_next ^ ~port_if.active_low;
		end
	end
	always_ff @(posedge aclk or posedge port_if.six_clear) begin
		if (port_if.six_clear) begin
			six_carry <= 4'h0;
		end else if (!aresetn) begin
			six_carry <= 4'h0;
		end else if (port_if.six_step) begin
			six_carry <= {1'b0, col[3:1]};
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			six_q <= 1'b0;
		end else if (port_if.six_step) begin
			six_q <= col[0];
		end
	end
	assign port_if.sum_bit = sum_q;
	assign port_if.carry_state = carry_ff;
	assign port_if.six_sum = six_q;
	assign port_if.six_carries = six_carry;
endmodule
`default_nettype wire

/* testbench/addsub_chk.sv */
// Checker: register bus handshakes of the add/subtract unit.
// Assumes it is bound into the top module and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module addsub_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp
);
	// ==========================================================
	// Properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence both_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence answer_second;
		!bvalid ##1 bvalid;
	endsequence
	wr_latency_a: assert property (both_taken |=> answer_second) else $error("late write answer");
	rd_latency_a: assert property (arvalid && arready |=> rvalid) else $error("late read answer");
	rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read dropped");
	wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("resp dropped");
	ar_block_a: assert property (rvalid |-> !arready) else $error("read accepted while busy");
	aw_block_a: assert property (bvalid |-> !awready && !wready) else $error("write accepted while busy");
	err_zero_a: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0) else $error("error read data");
	reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid) else $error("busy after reset");
endmodule
bind binary_bcd_add_subtract_unit addsub_chk chk (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
);
`default_nettype wire

/* testbench/addsub_host.sv */
// Host control model: bus master that supplies operands, steps and mode.
// Assumes one clock; the bench calls wr and rd one at a time.
`timescale 1ns/1ns
`default_nettype none
module addsub_host (
	// Clock
	input  wire logic        aclk,
	// Requests
	output logic [31:0]      awaddr,
	output logic             awvalid,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	output logic             bready,
	output logic [31:0]      araddr,
	output logic             arvalid,
	output logic             rready,
	// Answers
	input  wire logic        awready,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid
);
	// ==========================================================
	// Bus cycles
	// Cycles that an answer is left waiting before ready rises
	int lag = 0;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	end
	task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (lag == 0);
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		if (lag != 0) begin
			repeat (lag) @(posedge aclk);
			bready <= 1'b1;
			@(posedge aclk);
		end
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (lag == 0);
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		if (lag != 0) begin
			repeat (lag) @(posedge aclk);
			rready <= 1'b1;
			@(posedge aclk);
		end
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* testbench/binary_bcd_add_subtract_unit_tb.sv */
// Bench: parallel, serial, six-operand and decimal tests over the bus.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "addsub_cfg.svh"
module binary_bcd_add_subtract_unit_tb;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata, d, e;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  awprot = 3'h0;
	logic [2:0]  arprot = 3'h0;
	int          n_fail = 0;
	int          checked = 0;
	int          cycles = 0;
	logic [17:0] pt [8] = '{18'h07f01, 18'h0fcfd, 18'h10e07, 18'h1070e, 18'h18001, 18'h20ef8, 18'h30e07, 18'h2fbfc};
	binary_bcd_add_subtract_unit dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
	);
	addsub_host host (
		.aclk(aclk),
		.awaddr(awaddr), .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .rready(rready),
		.awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid)
	);
	// ==========================================================
	// Clock, timeout and helpers
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail = n_fail + 1;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic w(input logic [31:0] a, input logic [31:0] v);
		host.wr(a, v, r);
	endtask
	task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] x);
		host.rd(a, d, r);
		chk(nm, d, x);
	endtask
	task automatic sstep(input logic a, input logic b, input logic x);
		w(`OFS_SERIAL, {30'h0, b, a});
		host.rd(`OFS_SERIAL, d, r);
		chk("serial sum", {31'h0, d[0]}, {31'h0, x});
	endtask
	// Digits go in least significant bit first, one step each
	task automatic bpass(input logic m, input logic [19:0] v);
		w(`OFS_BCD_CMD, {30'h0, m, 1'b0});
		for (int i = 0; i < 20; i++) w(`OFS_BCD_CMD, {29'h0, 1'b1, m, v[i]});
	endtask
	// Ones complement results are checked on the sum field only
	function automatic logic [31:0] par_exp(input logic [7:0] a, input logic [7:0] b, input logic s, input logic o);
		logic [7:0] bb;
		logic [8:0] t;
		logic       c7;
		logic       ov;
		bb = s ? ~b : b;
		t = a + bb + (o ? 1'b0 : s);
		c7 = a[6:0] + bb[6:0] + s > 8'h7f;
		ov = c7 ^ t[8];
		if (o) return {24'h0, t[7:0] + {7'h0, t[8]}};
		return {19'h0, ~t[8], ov, ov, ov, t};
	endfunction
	// ==========================================================
	// Tests
	initial begin
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rc("ctrl reset", `OFS_CTRL, 32'h0);
		rc("bcd reset", `OFS_BCD_CMD, 32'h60);
		rc("unmapped", 32'h20, 32'h0);
		chk("unmapped resp", {30'h0, r}, 32'h2);
		// Answers left waiting a while must stand until ready rises
		host.lag = 2;
		w(`OFS_OPERAND_A, 32'h5a);
		rc("slow ready", `OFS_OPERAND_A, 32'h5a);
		host.lag = 0;
		host.wr(`OFS_PAR_RESULT, 32'h0, r);
		chk("read-only write", {30'h0, r}, 32'h2);
		foreach (pt[i]) begin
			w(`OFS_OPERAND_A, {24'h0, pt[i][15:8]});
			w(`OFS_OPERAND_B, {24'h0, pt[i][7:0]});
			w(`OFS_CTRL, {30'h0, pt[i][17:16]});
			host.rd(`OFS_PAR_RESULT, d, r);
			e = par_exp(pt[i][15:8], pt[i][7:0], pt[i][16], pt[i][17]);
			chk("parallel", pt[i][17] ? d & 32'hff : d, e);
		end
		$display("parallel done");
		w(`OFS_CTRL, 32'h0);
		w(`OFS_SERIAL, 32'h100);
		sstep(1'b1, 1'b1, 1'b0);
		sstep(1'b0, 1'b0, 1'b1);
		w(`OFS_CTRL, 32'h4);
		w(`OFS_SERIAL, 32'h100);
		sstep(1'b0, 1'b0, 1'b1);
		sstep(1'b1, 1'b1, 1'b0);
		w(`OFS_CTRL, 32'h1);
		w(`OFS_SERIAL, 32'h100);
		sstep(1'b0, 1'b1, 1'b1);
		sstep(1'b0, 1'b0, 1'b1);
		w(`OFS_CTRL, 32'h5);
		w(`OFS_SERIAL, 32'h100);
		sstep(1'b1, 1'b0, 1'b0);
		sstep(1'b0, 1'b1, 1'b1);
		$display("serial done");
		w(`OFS_SIX, 32'h100);
		w(`OFS_SIX, 32'h3f);
		rc("six full", `OFS_SIX, 32'h6);
		w(`OFS_SIX, 32'h0);
		rc("six carry", `OFS_SIX, 32'h3);
		w(`OFS_SIX, 32'h100);
		rc("six clear", `OFS_SIX, 32'h1);
		$display("six done");
		w(`OFS_BCD_CMD, 32'h100);
		bpass(1'b1, 20'h00009);
		rc("bcd load", `OFS_BCD_ACC, 32'h00009);
		bpass(1'b1, 20'h00001);
		rc("bcd add six", `OFS_BCD_ACC, 32'h00010);
		bpass(1'b1, 20'h00095);
		rc("bcd carry", `OFS_BCD_ACC, 32'h00105);
		bpass(1'b0, 20'h00006);
		rc("bcd borrow", `OFS_BCD_ACC, 32'h00099);
		host.rd(`OFS_BCD_CMD, d, r);
		chk("bcd home", {26'h0, d[5:0]}, 32'h0);
		$display("bcd done");
		print_verdict();
	end
endmodule
`default_nettype wire
